/* oms_defs.vh */
// Constants for the operation mode and command source selector.
//------------------------------------------------------------------------------
// Behaviour
//------------------------------------------------------------------------------
`ifndef OMS_DEFS_VH
`define OMS_DEFS_VH

// Register indices on the settings port.
`define OMS_A_POM        4'h0
`define OMS_A_SEL        4'h1
`define OMS_A_START      4'h2
`define OMS_A_FREQ       4'h3
`define OMS_A_NET        4'h4
`define OMS_A_PANEL      4'h5
`define OMS_A_COAST      4'h6
`define OMS_A_WPROT      4'h7
`define OMS_A_UGRP       4'h8
`define OMS_A_STATUS     4'h9
`define OMS_A_CTRL       4'ha

// Reset values of the settings.
`define OMS_RST_POM      16'h0000
`define OMS_RST_SEL      16'h0000
`define OMS_RST_START    16'h0000
`define OMS_RST_FREQ     16'h0000
`define OMS_RST_NET      16'h270f
`define OMS_RST_PANEL    16'h0002
`define OMS_RST_COAST    16'h270f
`define OMS_RST_WPROT    16'h0000
`define OMS_RST_UGRP     16'h0000

// Special setting values.
`define OMS_V_9999       16'h270f

// Operation modes.
`define OMS_M_EXT        2'h0
`define OMS_M_PU         2'h1
`define OMS_M_NET        2'h2
`define OMS_M_COMB       2'h3

// Command ports.
`define OMS_P_PANEL      2'h0
`define OMS_P_RS485      2'h1
`define OMS_P_OPTION     2'h2
`define OMS_P_TERMINAL   2'h3

// Control register fields and status register fields.
`define OMS_CTRL_RESET   0
`define OMS_ST_MODE_LO   0
`define OMS_ST_PORT_LO   2
`define OMS_ST_RUN       4
`define OMS_ST_REFUSED   5

`endif

/* oms_mode_select.v */
// Operation mode selection and command source routing.
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.vh"

module oms_mode_select
(
    // Clock and reset
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // Settings port
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [15:0] reg_rdata_o,
    // Mode switching
    input  wire        sw_req_i,
    input  wire [1:0]  sw_target_i,
    input  wire        mode_key_i,
    input  wire        mode_toggle_input_i,
    input  wire        output_stop_signal_i,
    // Drive state
    input  wire        motor_running_i,
    input  wire        option_fitted_i,
    input  wire        power_restore_i,
    input  wire        run_req_i,
    // Results
    output reg  [1:0]  mode_o,
    output reg  [1:0]  cmd_port_o,
    output reg         start_src_ext_o,
    output reg         freq_src_ext_o,
    output reg         freq_comm_ok_o,
    output reg         analog_ignore_o,
    output reg         run_cmd_o,
    output reg         sw_refused_o
);

    // ---------------------------------------------------------------------
    // Settings
    // ---------------------------------------------------------------------
    reg  [15:0] power_on_mode_setting;
    reg  [15:0] operation_mode_selection;
    reg  [15:0] start_source_setting;
    reg  [15:0] frequency_source_setting;
    reg  [15:0] network_source_setting;
    reg  [15:0] panel_source_setting;
    reg  [15:0] restart_coasting_setting;
    reg  [15:0] parameter_write_protection;
    reg  [15:0] user_group_read_selection;
    reg         init_pending;
    reg         start_blocked;
    wire [15:0] net_applied;
    wire [15:0] panel_applied;
    wire        soft_reset;
    wire        src_wr_ok;
    wire        sel_wr_ok;
    wire        resume;

    assign soft_reset = reg_wr_i && (reg_addr_i == `OMS_A_CTRL) && reg_wdata_i[`OMS_CTRL_RESET];
    assign src_wr_ok  = (user_group_read_selection == 16'h0000) || option_fitted_i;
    // Operation mode selection follows write protection; the others do not.
    assign sel_wr_ok  = (parameter_write_protection != 16'h0001) &&
                        (!motor_running_i || parameter_write_protection == 16'h0002);
    assign resume     = (power_on_mode_setting == 16'h0002 || power_on_mode_setting == 16'h000c) &&
                        (restart_coasting_setting != `OMS_V_9999);

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            power_on_mode_setting      <= `OMS_RST_POM;
            operation_mode_selection   <= `OMS_RST_SEL;
            start_source_setting       <= `OMS_RST_START;
            frequency_source_setting   <= `OMS_RST_FREQ;
            network_source_setting     <= `OMS_RST_NET;
            panel_source_setting       <= `OMS_RST_PANEL;
            restart_coasting_setting   <= `OMS_RST_COAST;
            parameter_write_protection <= `OMS_RST_WPROT;
            user_group_read_selection  <= `OMS_RST_UGRP;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `OMS_A_POM:   power_on_mode_setting <= reg_wdata_i;
                `OMS_A_SEL:
                begin
                    if (sel_wr_ok)
                        operation_mode_selection <= reg_wdata_i;
                end
                `OMS_A_START:
                begin
                    if (src_wr_ok)
                        start_source_setting <= reg_wdata_i;
                end
                `OMS_A_FREQ:
                begin
                    if (src_wr_ok)
                        frequency_source_setting <= reg_wdata_i;
                end
                `OMS_A_NET:
                begin
                    if (src_wr_ok)
                        network_source_setting <= reg_wdata_i;
                end
                `OMS_A_PANEL:
                begin
                    if (src_wr_ok)
                        panel_source_setting <= reg_wdata_i;
                end
                `OMS_A_COAST: restart_coasting_setting   <= reg_wdata_i;
                `OMS_A_WPROT: parameter_write_protection <= reg_wdata_i;
                `OMS_A_UGRP:  user_group_read_selection  <= reg_wdata_i;
                default:      ;
            endcase
        end
    end

    // Network and panel source settings in force, refreshed only at reset or reset command.
    oms_src_hold u_src_hold
    (
        .mclk_i          (mclk_i),
        .sys_rst_i       (sys_rst_i),
        .apply_i         (init_pending || soft_reset),
        .net_set_i       (network_source_setting),
        .panel_set_i     (panel_source_setting),
        .net_applied_o   (net_applied),
        .panel_applied_o (panel_applied)
    );

    // ---------------------------------------------------------------------
    // Mode decisions
    // ---------------------------------------------------------------------
    function is_pn;
        input [15:0] pom;
        begin
            is_pn = (pom == 16'h000a) || (pom == 16'h000c);
        end
    endfunction

    function [1:0] startup_mode;
        input [15:0] pom;
        input [15:0] sel;
        input        stop_on;
        reg          net_start;
        begin
            net_start = (pom == 16'h0001) || (pom == 16'h0002) || is_pn(pom);
            case (sel)
                16'h0001: startup_mode = `OMS_M_PU;
                16'h0003,
                16'h0004: startup_mode = `OMS_M_COMB;
                16'h0000,
                16'h0002,
                16'h0006: startup_mode = net_start ? `OMS_M_NET : `OMS_M_EXT;
                16'h0007: startup_mode = (net_start && stop_on) ? `OMS_M_NET : `OMS_M_EXT;
                default:  startup_mode = `OMS_M_EXT;
            endcase
        end
    endfunction

    function switch_ok;
        input [15:0] pom;
        input [15:0] sel;
        input        stop_on;
        input        running;
        input [1:0]  cur;
        input [1:0]  tgt;
        input        net_blocked;
        reg          run_ok;
        begin
            run_ok = !running || (sel == 16'h0006);
            if (cur == tgt || (tgt == `OMS_M_NET && net_blocked) || tgt == `OMS_M_COMB)
                switch_ok = 1'b0;
            else if (is_pn(pom) && (sel == 16'h0000 || sel == 16'h0006))
                switch_ok = run_ok && (cur != `OMS_M_EXT) && (tgt != `OMS_M_EXT);
            else if (is_pn(pom) && sel == 16'h0002)
                switch_ok = 1'b0;
            else
            begin
                case (sel)
                    16'h0000,
                    16'h0006: switch_ok = run_ok && (cur == `OMS_M_EXT || tgt == `OMS_M_EXT);
                    16'h0007: switch_ok = run_ok && stop_on &&
                                          (cur == `OMS_M_EXT || tgt == `OMS_M_EXT);
                    16'h0002: switch_ok = run_ok && (tgt != `OMS_M_PU) && (cur != `OMS_M_PU);
                    default:  switch_ok = 1'b0;
                endcase
            end
        end
    endfunction

    // Network mode cannot be switched to when both sources name the RS-485
    // terminals and no option is fitted, because panel mode owns the port.
    wire       net_blocked;
    wire       toggle_req;
    wire [1:0] toggle_tgt;
    wire [1:0] req_tgt;
    wire       any_req;
    wire       req_ok;
    wire [1:0] boot_mode;

    assign net_blocked = (net_applied == 16'h0001) && (panel_applied == 16'h0001) && !option_fitted_i;
    assign toggle_req  = is_pn(power_on_mode_setting) && (mode_key_i || mode_toggle_input_i);
    assign toggle_tgt  = (mode_o == `OMS_M_PU) ? `OMS_M_NET : `OMS_M_PU;
    assign req_tgt     = toggle_req ? toggle_tgt : sw_target_i;
    assign any_req     = toggle_req || sw_req_i;
    assign req_ok      = switch_ok(power_on_mode_setting, operation_mode_selection, output_stop_signal_i,
                                   motor_running_i, mode_o, req_tgt, net_blocked);
    assign boot_mode   = startup_mode(power_on_mode_setting, operation_mode_selection, output_stop_signal_i);

    // ---------------------------------------------------------------------
    // Mode register
    // ---------------------------------------------------------------------
    // Settings are taken one edge after the reset release, never under the
    // reset itself, so the mode register sees settled setting values.
    reg [1:0] next_mode;
    reg       next_refused;

    always @*
    begin
        next_mode    = mode_o;
        next_refused = 1'b0;
        if (init_pending || soft_reset)
            next_mode = boot_mode;
        else if (power_restore_i && !resume)
            next_mode = boot_mode;
        else if (operation_mode_selection == 16'h0007 && !output_stop_signal_i)
        begin
            next_mode    = `OMS_M_EXT;
            next_refused = any_req;
        end
        else if (any_req)
        begin
            if (req_ok)
                next_mode = req_tgt;
            else
                next_refused = 1'b1;
        end
    end

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            init_pending <= 1'b1;
            mode_o       <= `OMS_M_EXT;
            sw_refused_o <= 1'b0;
        end
        else
        begin
            init_pending <= 1'b0;
            mode_o       <= next_mode;
            sw_refused_o <= next_refused;
        end
    end

    // ---------------------------------------------------------------------
    // Start command
    // ---------------------------------------------------------------------
    // A blocked start stays off until the request itself is withdrawn, so a
    // restored supply with power-on mode 1 or 10 never restarts the motor on a stale level.
    wire clear_start;
    assign clear_start = power_restore_i && run_req_i &&
                         (power_on_mode_setting == 16'h0001 || power_on_mode_setting == 16'h000a);

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            start_blocked <= 1'b0;
            run_cmd_o     <= 1'b0;
        end
        else
        begin
            if (clear_start)
                start_blocked <= 1'b1;
            else if (!run_req_i)
                start_blocked <= 1'b0;
            run_cmd_o <= run_req_i && !start_blocked && !clear_start;
        end
    end

    // ---------------------------------------------------------------------
    // Command sources
    // ---------------------------------------------------------------------
    reg [1:0] next_port;

    always @*
    begin
        case (mode_o)
            `OMS_M_NET:
            begin
                if (net_applied == 16'h0000)
                    next_port = `OMS_P_OPTION;
                else if (net_applied == 16'h0001)
                    next_port = `OMS_P_RS485;
                else
                    next_port = option_fitted_i ? `OMS_P_OPTION : `OMS_P_RS485;
            end
            `OMS_M_PU:
                next_port = (panel_applied == 16'h0001) ? `OMS_P_RS485 : `OMS_P_PANEL;
            default:
                next_port = `OMS_P_TERMINAL;
        endcase
    end

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            cmd_port_o      <= `OMS_P_TERMINAL;
            start_src_ext_o <= 1'b0;
            freq_src_ext_o  <= 1'b0;
            freq_comm_ok_o  <= 1'b1;
            analog_ignore_o <= 1'b0;
        end
        else
        begin
            cmd_port_o      <= next_port;
            start_src_ext_o <= (start_source_setting == 16'h0001);
            freq_src_ext_o  <= (frequency_source_setting == 16'h0001) ||
                               (frequency_source_setting == 16'h0002);
            freq_comm_ok_o  <= (frequency_source_setting != 16'h0001);
            analog_ignore_o <= (frequency_source_setting == 16'h0002);
        end
    end

    // ---------------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------------
    reg [15:0] next_rdata;

    always @*
    begin
        case (reg_addr_i)
            `OMS_A_POM:    next_rdata = power_on_mode_setting;
            `OMS_A_SEL:    next_rdata = operation_mode_selection;
            `OMS_A_START:  next_rdata = start_source_setting;
            `OMS_A_FREQ:   next_rdata = frequency_source_setting;
            `OMS_A_NET:    next_rdata = network_source_setting;
            `OMS_A_PANEL:  next_rdata = panel_source_setting;
            `OMS_A_COAST:  next_rdata = restart_coasting_setting;
            `OMS_A_WPROT:  next_rdata = parameter_write_protection;
            `OMS_A_UGRP:   next_rdata = user_group_read_selection;
            `OMS_A_STATUS: next_rdata = {10'h000, sw_refused_o, run_cmd_o, cmd_port_o, mode_o};
            default:       next_rdata = 16'h0000;
        endcase
    end

    // Read data stand for exactly one cycle after the strobe.
    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
        else
            reg_rdata_o <= 16'h0000;
    end

endmodule // oms_mode_select
`default_nettype wire

/* oms_mode_select_assertions.sv */
// Port checker for the operation mode selector.
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.vh"
module oms_mode_select_assertions
(
    // Clock and reset
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    // Requests
    input wire logic       reg_wr_i,
    input wire logic       sw_req_i,
    input wire logic       mode_key_i,
    input wire logic       mode_toggle_input_i,
    input wire logic       output_stop_signal_i,
    input wire logic       power_restore_i,
    input wire logic       run_req_i,
    // Results
    input wire logic [1:0] mode_o,
    input wire logic [1:0] cmd_port_o,
    input wire logic       freq_src_ext_o,
    input wire logic       freq_comm_ok_o,
    input wire logic       analog_ignore_o,
    input wire logic       run_cmd_o,
    input wire logic       sw_refused_o
);
    // ----
    // Properties
    // ----
    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire logic any_req = sw_req_i || mode_key_i || mode_toggle_input_i;
    wire logic reload = power_restore_i || reg_wr_i || !output_stop_signal_i;
    property p_refuse_cause;
        sw_refused_o |-> $past(any_req);
    endproperty
    a_refuse_cause: assert property (p_refuse_cause) else $error("refusal without request");
    // Reset release takes two edges to show, so both depths are allowed.
    property p_mode_cause;
        !$stable(mode_o) |-> $past(any_req || reload || sys_rst_i) || $past(sys_rst_i, 2) || $past(reg_wr_i, 2);
    endproperty
    a_mode_cause: assert property (p_mode_cause) else $error("mode moved without cause");
    property p_comb_fixed;
        mode_o == `OMS_M_COMB && sw_req_i && !reg_wr_i && !power_restore_i |=> mode_o == `OMS_M_COMB;
    endproperty
    a_comb_fixed: assert property (p_comb_fixed) else $error("combined mode left");
    property p_freq_ign;
        analog_ignore_o |-> freq_src_ext_o && freq_comm_ok_o;
    endproperty
    a_freq_ign: assert property (p_freq_ign) else $error("analog ignore outside setting 2");
    property p_freq_comm;
        !freq_src_ext_o |-> freq_comm_ok_o && !analog_ignore_o;
    endproperty
    a_freq_comm: assert property (p_freq_comm) else $error("communication frequency lost");
    property p_port_pu;
        $past(mode_o) == `OMS_M_PU |-> cmd_port_o == `OMS_P_PANEL || cmd_port_o == `OMS_P_RS485;
    endproperty
    a_port_pu: assert property (p_port_pu) else $error("panel mode port wrong");
    property p_port_net;
        $past(mode_o) == `OMS_M_NET |-> cmd_port_o == `OMS_P_RS485 || cmd_port_o == `OMS_P_OPTION;
    endproperty
    a_port_net: assert property (p_port_net) else $error("network mode port wrong");
    property p_run_rise;
        $rose(run_cmd_o) |-> $past(run_req_i);
    endproperty
    a_run_rise: assert property (p_run_rise) else $error("start without request");
endmodule // oms_mode_select_assertions
bind oms_mode_select oms_mode_select_assertions u_chk
(
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .sw_req_i(sw_req_i), .mode_key_i(mode_key_i),
    .mode_toggle_input_i(mode_toggle_input_i), .output_stop_signal_i(output_stop_signal_i),
    .power_restore_i(power_restore_i), .run_req_i(run_req_i), .mode_o(mode_o), .cmd_port_o(cmd_port_o),
    .freq_src_ext_o(freq_src_ext_o), .freq_comm_ok_o(freq_comm_ok_o), .analog_ignore_o(analog_ignore_o),
    .run_cmd_o(run_cmd_o), .sw_refused_o(sw_refused_o)
);
`default_nettype wire

/* oms_net_master.sv */
// Network master model that drives the start command and option presence.
`timescale 1ns/1ps
`default_nettype none
module oms_net_master
(
    // Clock
    input  wire logic mclk_i,
    // Orders from the bench
    input  wire logic run_i,
    input  wire logic opt_i,
    // Lines toward the drive
    output var  logic run_req_o,
    output var  logic option_fitted_o
);
    // ----
    // Line drivers
    // ----
    // Registered, so the lines only move just after a clock edge.
    always_ff @(posedge mclk_i)
    begin
        run_req_o       <= run_i;
        option_fitted_o <= opt_i;
    end
endmodule // oms_net_master
`default_nettype wire

/* oms_src_hold.v */
// Applied copy of the Network and panel source settings.
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.vh"

module oms_src_hold
(
    // Clock and reset
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // Apply strobe and written settings
    input  wire        apply_i,
    input  wire [15:0] net_set_i,
    input  wire [15:0] panel_set_i,
    // Values in force
    output reg  [15:0] net_applied_o,
    output reg  [15:0] panel_applied_o
);

    // ---------------------------------------------------------------------
    // Hold until apply
    // ---------------------------------------------------------------------
    // The written values only take hold at an apply strobe, so a source
    // change never pulls the command port away in the middle of running.
    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            net_applied_o   <= `OMS_RST_NET;
            panel_applied_o <= `OMS_RST_PANEL;
        end
        else if (apply_i)
        begin
            net_applied_o   <= net_set_i;
            panel_applied_o <= panel_set_i;
        end
    end

endmodule // oms_src_hold
`default_nettype wire

/* tb_oms_mode_select.sv */
// Self-checking bench for the operation mode selector.
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.vh"
module tb_oms_mode_select;
    localparam [1:0] EX = `OMS_M_EXT, PU = `OMS_M_PU, NT = `OMS_M_NET, CB = `OMS_M_COMB;
    localparam [1:0] RQ = 2'h0, KY = 2'h1, TG = 2'h2;
    logic        mclk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, req = 0, key = 0, tog = 0;
    logic        stop = 1, mot = 0, pwr = 0, run = 0, opt = 0;
    logic [3:0]  addr = 0;
    logic [15:0] wdata = 0;
    logic [1:0]  tgt = 0;
    wire  [15:0] rdata;
    wire  [1:0]  mode, port;
    wire         sext, fext, fcom, aign, rcmd, refd, run_q, opt_q;
    int          n_errors = 0, comparisons = 0, i, j;
    oms_net_master u_nm (.mclk_i(mclk_i), .run_i(run), .opt_i(opt), .run_req_o(run_q), .option_fitted_o(opt_q));
    oms_mode_select DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sw_req_i(req), .sw_target_i(tgt), .mode_key_i(key),
        .mode_toggle_input_i(tog), .output_stop_signal_i(stop), .motor_running_i(mot), .option_fitted_i(opt_q),
        .power_restore_i(pwr), .run_req_i(run_q), .mode_o(mode), .cmd_port_o(port), .start_src_ext_o(sext),
        .freq_src_ext_o(fext), .freq_comm_ok_o(fcom), .analog_ignore_o(aign), .run_cmd_o(rcmd), .sw_refused_o(refd));
    // ----
    // Access and compare tasks
    // ----
    initial forever #2 mclk_i = ~mclk_i;
    task w(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task ck(input [15:0] g, input [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task ckm(input [1:0] e);
        ck({14'h0, mode}, {14'h0, e});
    endtask
    task ckp(input [1:0] e);
        w(1);
        ck({14'h0, port}, {14'h0, e});
    endtask
    task wrt(input [3:0] a, input [15:0] v);
        @(posedge mclk_i);
        wr <= 1;
        addr <= a;
        wdata <= v;
        @(posedge mclk_i);
        wr <= 0;
    endtask
    task rdt(input [3:0] a, input [15:0] e);
        @(posedge mclk_i);
        rd <= 1;
        addr <= a;
        @(posedge mclk_i);
        rd <= 0;
        #1;
        ck(rdata, e);
    endtask
    task p(input [1:0] k, input [1:0] t, input [1:0] em, input er);
        @(posedge mclk_i);
        req <= (k == RQ);
        key <= (k == KY);
        tog <= (k == TG);
        tgt <= t;
        @(posedge mclk_i);
        req <= 0;
        key <= 0;
        tog <= 0;
        #1;
        ckm(em);
        ck({15'h0, refd}, {15'h0, er});
    endtask
    task pr;
        @(posedge mclk_i);
        pwr <= 1;
        @(posedge mclk_i);
        pwr <= 0;
        w(1);
    endtask
    task rst;
        @(posedge mclk_i);
        sys_rst_i <= 1;
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 0;
        w(2);
    endtask
    // The startup mode only reaches the mode register through a reload, so each case ends with one.
    task cfg(input [15:0] pm, input [15:0] s);
        rst;
        // Protection 2 lets the selection be written while the motor runs.
        wrt(4'h7, 16'h0002);
        wrt(4'h0, pm);
        wrt(4'h1, s);
        wrt(4'ha, 16'h0001);
        w(3);
    endtask
    task conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude;
    end
    initial
    begin
        rst;
        for (i = 0; i < 9; i++)
            rdt(i[3:0], (i == 4 || i == 6) ? 16'h270f : (i == 5) ? 16'h0002 : 16'h0000);
        rdt(4'h9, 16'h000c);
        rdt(4'hf, 16'h0000);
        for (i = 0; i < 3; i++)
        begin
            wrt(4'h3, i[15:0]);
            wrt(4'h2, {15'h0, i[0]});
            w(3);
            ck({13'h0, fext, fcom, aign}, {13'h0, i != 0, i != 1, i == 2});
            ck({15'h0, sext}, {15'h0, i[0]});
        end
        wrt(4'h8, 16'h0001);
        wrt(4'h2, 16'h0001);
        rdt(4'h2, 16'h0000);
        wrt(4'h5, 16'h0001);
        rdt(4'h5, 16'h0002);
        opt <= 1;
        w(3);
        wrt(4'h5, 16'h0001);
        rdt(4'h5, 16'h0001);
        wrt(4'h7, 16'h0001);
        wrt(4'h0, 16'h000a);
        rdt(4'h0, 16'h000a);
        opt <= 0;
        $display("test settings done");
        cfg(16'h0000, 16'h0000);
        p(RQ, PU, PU, 1'b0);
        p(RQ, NT, PU, 1'b1);
        p(RQ, EX, EX, 1'b0);
        p(RQ, NT, NT, 1'b0);
        p(RQ, PU, NT, 1'b1);
        p(RQ, CB, NT, 1'b1);
        cfg(16'h0000, 16'h0001);
        ckm(PU);
        p(RQ, EX, PU, 1'b1);
        cfg(16'h0000, 16'h0002);
        p(RQ, PU, EX, 1'b1);
        p(RQ, NT, NT, 1'b0);
        for (i = 3; i < 5; i++)
        begin
            cfg(16'h0000, i[15:0]);
            ckm(CB);
            p(RQ, EX, CB, 1'b1);
        end
        cfg(16'h0000, 16'h0007);
        p(RQ, PU, PU, 1'b0);
        stop <= 0;
        w(2);
        ckm(EX);
        p(RQ, PU, EX, 1'b1);
        stop <= 1;
        mot <= 1;
        cfg(16'h0000, 16'h0000);
        p(RQ, PU, EX, 1'b1);
        cfg(16'h0000, 16'h0006);
        p(RQ, PU, PU, 1'b0);
        cfg(16'h000a, 16'h0006);
        p(KY, EX, PU, 1'b0);
        mot <= 0;
        $display("test switching done");
        for (i = 0; i < 4; i++)
            for (j = 0; j < 3; j++)
            begin
                cfg(16'(i < 2 ? i + 1 : 2 * i + 6), 16'(j * (j + 1)));
                ckm(NT);
            end
        cfg(16'h0001, 16'h0007);
        ckm(NT);
        cfg(16'h000a, 16'h0000);
        p(KY, EX, PU, 1'b0);
        p(TG, EX, NT, 1'b0);
        p(RQ, EX, NT, 1'b1);
        cfg(16'h000c, 16'h0002);
        p(KY, EX, NT, 1'b1);
        $display("test startup done");
        cfg(16'h0002, 16'h0000);
        wrt(4'h6, 16'h0005);
        p(RQ, EX, EX, 1'b0);
        pr;
        ckm(EX);
        wrt(4'h6, 16'h270f);
        pr;
        ckm(NT);
        cfg(16'h0001, 16'h0000);
        run <= 1;
        w(4);
        ck({15'h0, rcmd}, 16'h0001);
        p(RQ, EX, EX, 1'b0);
        pr;
        ckm(NT);
        w(3);
        ck({15'h0, rcmd}, 16'h0000);
        run <= 0;
        w(4);
        run <= 1;
        w(4);
        ck({15'h0, rcmd}, 16'h0001);
        run <= 0;
        $display("test restore done");
        cfg(16'h0000, 16'h0000);
        p(RQ, NT, NT, 1'b0);
        ckp(`OMS_P_RS485);
        opt <= 1;
        wrt(4'h4, 16'h0001);
        p(RQ, EX, EX, 1'b0);
        p(RQ, NT, NT, 1'b0);
        ckp(`OMS_P_OPTION);
        wrt(4'ha, 16'h0001);
        w(3);
        p(RQ, NT, NT, 1'b0);
        ckp(`OMS_P_RS485);
        p(RQ, EX, EX, 1'b0);
        p(RQ, PU, PU, 1'b0);
        ckp(`OMS_P_PANEL);
        wrt(4'h5, 16'h0001);
        wrt(4'ha, 16'h0001);
        w(3);
        p(RQ, PU, PU, 1'b0);
        ckp(`OMS_P_RS485);
        opt <= 0;
        p(RQ, EX, EX, 1'b0);
        p(RQ, NT, EX, 1'b1);
        $display("test sources done");
        conclude;
    end
endmodule // tb_oms_mode_select
`default_nettype wire
